/* bench/ppm_pin_model.sv */
// ppm_pin_model: board circuitry hanging on the port A and port B pins.
// assumes the dut's out/oe_n/pullup controls; the bench sets board drive.
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_pa_out,
    input  wire logic [7:0] i_pa_oe_n,
    input  wire logic [7:0] i_pa_pull,
    input  wire logic [7:0] i_pa_ext,
    input  wire logic [7:0] i_pa_en,
    input  wire logic [5:0] i_pb_out,
    input  wire logic [5:0] i_pb_oe_n,
    input  wire logic [5:0] i_pb_pull,
    input  wire logic [5:0] i_pb_ext,
    input  wire logic [5:0] i_pb_en,
    output logic      [7:0] o_pa,
    output logic      [5:0] o_pb
);
    logic [7:0] wander = 8'h5A;

    // a pin nobody holds toggles each cycle, so a stale level never reads
    always @(posedge i_clk) begin
        wander <= ~wander;
    end

    // dut drive wins, then the board driver, then the pull-high
    assign o_pa = (~i_pa_oe_n & i_pa_out) |
                  (i_pa_oe_n & i_pa_en & i_pa_ext) |
                  (i_pa_oe_n & ~i_pa_en & (i_pa_pull | wander));
    assign o_pb = (~i_pb_oe_n & i_pb_out) |
                  (i_pb_oe_n & i_pb_en & i_pb_ext) |
                  (i_pb_oe_n & ~i_pb_en & (i_pb_pull | wander[5:0]));
endmodule : ppm_pin_model
`default_nettype wire

/* bench/ppm_port_mux_props.sv */
// ppm_port_mux_props: bus, reset, analog gating and wake checks.
// assumes it is bound into ppm_port_mux; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mux_props (
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hresp,
    input wire logic [7:0]  i_pa_in,
    input wire logic [7:0]  o_pa_out,
    input wire logic [7:0]  o_pa_oe_n,
    input wire logic [5:0]  o_pb_out,
    input wire logic [5:0]  o_pb_oe_n,
    input wire logic [7:0]  o_pa_pullup,
    input wire logic [7:0]  o_pa_analog,
    input wire logic        i_sleep,
    input wire logic        o_timer1_ext_input,
    input wire logic        o_wake
);
    // a read address phase accepted by the slave
    wire rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    ////////////////////////////////////////////////////////////////////////
    // bus answers: one wait per read, data held until the next read
    AST_READ_WAIT: assert property (rd_take |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read data phase not exactly one wait");
    AST_RDATA_HOLD: assert property ($changed(o_hrdata) |-> $past(rd_take, 2))
        else $error("read data moved without a read");
    AST_HRESP_OKAY: assert property (o_hresp == 1'b0)
        else $error("slave response not okay");

    ////////////////////////////////////////////////////////////////////////
    // pin side relations
    AST_RST_VALUES: assert property ($fell(i_srst) |->
        o_pa_out == 8'hFF && o_pa_oe_n == 8'hFF && o_pb_out == 6'h3F &&
        o_pb_oe_n == 6'h3F && o_pa_pullup == 8'h00 && !o_wake)
        else $error("pins not at reset state after reset");
    AST_ANALOG_NO_PULL: assert property (
        (o_pa_analog & o_pa_pullup) == 8'h00)
        else $error("analog pin keeps its pull-high");
    AST_ANALOG_NO_DRIVE: assert property (
        (o_pa_analog & ~o_pa_oe_n) == 8'h00)
        else $error("analog pin still driven");
    AST_TMR1_LEVEL: assert property (
        o_timer1_ext_input |-> $past(i_pa_in[4]))
        else $error("timer1 input high while its pin was low");
    // wake only from a sampled falling edge while asleep
    AST_WAKE_CAUSE: assert property ($rose(o_wake) |->
        $past(i_sleep) && (($past(i_pa_in, 2) & ~$past(i_pa_in)) != 8'h00))
        else $error("wake without falling edge in sleep");

    COV_READ: cover property (rd_take ##2 o_hreadyout);
    COV_WAKE: cover property ($rose(o_wake));
    COV_TMR1: cover property ($rose(o_timer1_ext_input));
endmodule : ppm_port_mux_props

bind ppm_port_mux ppm_port_mux_props u_props (
    .i_clk, .i_srst, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
    .o_hreadyout, .o_hrdata, .o_hresp, .i_pa_in, .o_pa_out, .o_pa_oe_n,
    .o_pb_out, .o_pb_oe_n, .o_pa_pullup, .o_pa_analog, .i_sleep,
    .o_timer1_ext_input, .o_wake
);
`default_nettype wire

/* bench/ppm_port_mux_tb.sv */
// ppm_port_mux_tb: self-checking bench for the port pin function mux.
// assumes pin model and checker compiled first; one AHB-Lite slave.
`include "ppm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mux_tb;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        fdo = 1'b0;
    logic [1:0]  pwm = 2'h0;
    logic        sleep = 1'b0;
    logic [7:0]  pa_ext = 8'hFF;
    logic [7:0]  pa_en = 8'hFF;
    logic [5:0]  pb_ext = 6'h3F;
    logic [31:0] rnd = 32'h964C1DBA;
    logic        rd_ph = 1'b0;
    logic [31:0] exp_q[$];
    int          bad_count = 0;
    int          checks = 0;
    wire  [31:0] hrdata;
    wire         hready, hresp, irq, tm0, tm1, wake;
    wire  [7:0]  pa_in, pa_out, pa_oe_n, pa_pu, pa_an;
    wire  [5:0]  pb_in, pb_out, pb_oe_n, pb_pu;
    wire  [3:0]  bias;

    initial forever #5 i_clk = ~i_clk;

    ppm_port_mux u_dut (
        .i_clk, .i_srst, .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_pa_in(pa_in),
        .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n), .o_pa_pullup(pa_pu),
        .o_pa_analog(pa_an), .i_pb_in(pb_in), .o_pb_out(pb_out),
        .o_pb_oe_n(pb_oe_n), .o_pb_pullup(pb_pu), .o_pb_com_bias(bias),
        .i_freq_div_output(fdo), .i_pwm(pwm), .i_sleep(sleep),
        .o_ext_irq_pin(irq), .o_timer0_ext_input(tm0),
        .o_timer1_ext_input(tm1), .o_wake(wake)
    );
    ppm_pin_model u_pins (
        .i_clk, .i_pa_out(pa_out), .i_pa_oe_n(pa_oe_n), .i_pa_pull(pa_pu),
        .i_pa_ext(pa_ext), .i_pa_en(pa_en), .i_pb_out(pb_out),
        .i_pb_oe_n(pb_oe_n), .i_pb_pull(pb_pu), .i_pb_ext(pb_ext),
        .i_pb_en(6'h3F), .o_pa(pa_in), .o_pb(pb_in)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // one single transfer; a read notes its expected word first
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        if (!w) exp_q.push_back(d);
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge i_clk); while (hready !== 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, e);
    endtask : rd

    // pins follow a register one edge after the write lands
    task automatic settle;
        repeat (2) @(posedge i_clk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // read data watcher: oldest note against each completed read
    always @(posedge i_clk) begin
        if (rd_ph && hready === 1'b1 && exp_q.size() != 0)
            check("hrdata", hrdata, exp_q.pop_front());
        if (hready === 1'b1)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        logic [7:0] la;
        logic [5:0] lb;
        int         i;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        check("pa_out", 32'(pa_out), 32'hFF);
        check("pb_oe_n", 32'(pb_oe_n), 32'h3F);
        rd(`PPM_A_PA_DIR, 32'hFF);
        rd(`PPM_A_PB_DIR, 32'h3F);
        rd(`PPM_A_PA_WAKE, 32'h0);
        rd(`PPM_A_MISC, 32'h0);
        wr(8'h34, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0);
        rnd = lfsr(rnd);
        la = rnd[7:0];
        lb = rnd[13:8];
        pa_ext <= la;
        pb_ext <= lb;
        rd(`PPM_A_PA_DATA, 32'(la));
        rd(`PPM_A_PB_DATA, 32'(lb));
        // new outputs show the reset latch, then bit ops use live pins
        wr(`PPM_A_PA_DIR, 32'hF0);
        settle();
        check("pa_oe_n", 32'(pa_oe_n), 32'hF0);
        check("pa_out", 32'(pa_out[3:0]), 32'hF);
        wr(`PPM_A_BIT_OP, 32'h01);
        wr(`PPM_A_PA_DIR, 32'h00);
        wr(`PPM_A_BIT_OP, 32'h1D);
        wr(`PPM_A_PB_DIR, 32'h00);
        settle();
        la = {la[7:4], 4'hD};
        lb = lb | 6'h20;
        check("pa_out", 32'(pa_out), 32'(la));
        check("pb_out", 32'(pb_out), 32'(lb));
        wr(`PPM_A_BIT_OP, 32'h11);
        wr(`PPM_A_BIT_OP, 32'h08);
        settle();
        la = la | 8'h02;
        lb = lb & 6'h3E;
        check("pa_out", 32'(pa_out), 32'(la));
        check("pb_out", 32'(pb_out), 32'(lb));
        // every select and remap combination with outputs enabled
        for (i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            fdo <= rnd[0];
            pwm <= rnd[2:1];
            wr(`PPM_A_MISC, 32'(i));
            settle();
            check("pa1", 32'(pa_out[1]), 32'(i[0] && !i[3] ? rnd[0] : la[1]));
            check("pa5", 32'(pa_out[5]), 32'(i[1] ? rnd[1] : la[5]));
            check("pa6", 32'(pa_out[6]), 32'(i[2] ? rnd[2] : la[6]));
            check("pb3", 32'(pb_out[3]), 32'(i[0] && i[3] ? rnd[0] : lb[3]));
        end
        wr(`PPM_A_MISC, 32'h7);
        wr(`PPM_A_PA_DIR, 32'h62);
        settle();
        check("pa_oe_n", 32'(pa_oe_n), 32'h62);
        // timer codes against remap; PA2 low, PB4 high, PA3 high, PB5 low
        wr(`PPM_A_PA_DIR, 32'hFF);
        wr(`PPM_A_PB_DIR, 32'h3F);
        pa_ext <= 8'hFB;
        pb_ext <= 6'h1F;
        for (i = 0; i < 16; i++) begin
            wr(`PPM_A_TMR_MODE, 32'(i));
            wr(`PPM_A_MISC, {28'h0, i[3], 3'b000});
            settle();
            check("tm0", 32'(tm0), 32'(i[0] && i[3]));
            check("tm1", 32'(tm1), 32'(i[2]));
            check("irq", 32'(irq), 32'(!i[3]));
        end
        rd(`PPM_A_PA_DATA, 32'hFB);
        // pull-high, lcd common and analog selection
        wr(`PPM_A_PA_PULL, 32'hFF);
        wr(`PPM_A_LCD_COM, 32'hA);
        wr(`PPM_A_PB_PULL, 32'h3F);
        pa_en <= 8'h80;
        pa_ext <= 8'h00;
        settle();
        check("pa_pu", 32'(pa_pu), 32'h7F);
        check("bias", 32'(bias), 32'hA);
        check("pb_pu", 32'(pb_pu), 32'h35);
        rd(`PPM_A_PA_DATA, 32'h7F);
        rnd = lfsr(rnd);
        la = 8'h7F & ~rnd[7:0];
        wr(`PPM_A_ADC_CTRL, 32'(rnd[7:0]));
        settle();
        check("pa_an", 32'(pa_an), 32'(rnd[7:0]));
        check("pa_pu", 32'(pa_pu), 32'(la));
        rd(`PPM_A_MISC, 32'h8);
        wr(`PPM_A_ADC_CTRL, 32'h0);
        pa_en <= 8'hFF;
        pa_ext <= 8'hFF;
        // wake: awake fall and disabled fall are ignored
        wr(`PPM_A_PA_WAKE, 32'h10);
        pa_ext <= 8'hEF;
        settle();
        pa_ext <= 8'hFF;
        sleep <= 1'b1;
        settle();
        pa_ext <= 8'hFB;
        settle();
        check("wake", 32'(wake), 32'h0);
        pa_ext <= 8'hEB;
        settle();
        check("wake", 32'(wake), 32'h1);
        rd(`PPM_A_WAKE_STAT, 32'h10);
        wr(`PPM_A_WAKE_STAT, 32'h10);
        settle();
        check("wake", 32'(wake), 32'h0);
        sleep <= 1'b0;
        while (exp_q.size() != 0) @(posedge i_clk);
        complete_run();
    end
endmodule : ppm_port_mux_tb
`default_nettype wire

/* rtl/ppm_port_mux.sv */
// ppm_port_mux: port A/B registers and pin function selection behind an
// AHB-Lite slave.
// assumes pin inputs already synchronous to i_clk; pads resolve the
// out/oe_n/pullup/analog/bias controls into real pin levels.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`include "ppm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mux #(
    parameter int             ADC_PINS     = 8,
    parameter logic [7:0]     PA_PULL_MASK = 8'h7F
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic         i_hsel,
    input  wire logic [31:0]  i_haddr,
    input  wire logic [1:0]   i_htrans,
    input  wire logic         i_hwrite,
    input  wire logic [2:0]   i_hsize,
    input  wire logic [31:0]  i_hwdata,
    input  wire logic         i_hready,
    output logic      [31:0]  o_hrdata,
    output logic              o_hreadyout,
    output logic              o_hresp,
    input  wire logic [7:0]   i_pa_in,
    output logic      [7:0]   o_pa_out,
    output logic      [7:0]   o_pa_oe_n,
    output logic      [7:0]   o_pa_pullup,
    output logic      [7:0]   o_pa_analog,
    input  wire logic [5:0]   i_pb_in,
    output logic      [5:0]   o_pb_out,
    output logic      [5:0]   o_pb_oe_n,
    output logic      [5:0]   o_pb_pullup,
    output logic      [3:0]   o_pb_com_bias,
    input  wire logic         i_freq_div_output,
    input  wire logic [1:0]   i_pwm,
    input  wire logic         i_sleep,
    output logic              o_ext_irq_pin,
    output logic              o_timer0_ext_input,
    output logic              o_timer1_ext_input,
    output logic              o_wake
);
    import ppm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0]  port_a_data;
    logic [7:0]  port_a_direction;
    logic [7:0]  port_a_pullhigh_enable;
    logic [7:0]  port_a_wake_enable;
    logic [5:0]  port_b_data;
    logic [5:0]  port_b_direction;
    logic [5:0]  port_b_pullhigh_enable;
    logic [3:0]  misc_control_zero;
    logic [3:0]  lcd_common_control;
    logic [7:0]  adc_pin_config_bits;
    ppm_tmode_t  timer0_mode;
    ppm_tmode_t  timer1_mode;
    logic [7:0]  wake_flags;
    logic [7:0]  pa_prev;
    ppm_bus_t    bus_state;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [7:0]  rd_addr;

    // true when the pending data phase writes the given offset
    function automatic logic wr_hit(input logic       pend,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
        return pend && (a == off);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire       addr_take = i_hsel & i_hready & i_htrans[`PPM_HTRANS_ACT];
    wire       rd_take   = addr_take & ~i_hwrite;
    wire [7:0] wd8       = i_hwdata[7:0];

    wire we_pa_data = wr_hit(wr_pend, wr_addr, `PPM_A_PA_DATA);
    wire we_pa_dir  = wr_hit(wr_pend, wr_addr, `PPM_A_PA_DIR);
    wire we_pa_pull = wr_hit(wr_pend, wr_addr, `PPM_A_PA_PULL);
    wire we_pa_wake = wr_hit(wr_pend, wr_addr, `PPM_A_PA_WAKE);
    wire we_pb_data = wr_hit(wr_pend, wr_addr, `PPM_A_PB_DATA);
    wire we_pb_dir  = wr_hit(wr_pend, wr_addr, `PPM_A_PB_DIR);
    wire we_pb_pull = wr_hit(wr_pend, wr_addr, `PPM_A_PB_PULL);
    wire we_misc    = wr_hit(wr_pend, wr_addr, `PPM_A_MISC);
    wire we_lcd     = wr_hit(wr_pend, wr_addr, `PPM_A_LCD_COM);
    wire we_adc     = wr_hit(wr_pend, wr_addr, `PPM_A_ADC_CTRL);
    wire we_tmr     = wr_hit(wr_pend, wr_addr, `PPM_A_TMR_MODE);
    wire we_bop     = wr_hit(wr_pend, wr_addr, `PPM_A_BIT_OP);
    wire we_wstat   = wr_hit(wr_pend, wr_addr, `PPM_A_WAKE_STAT);

    ////////////////////////////////////////////////////////////////////
    // bit set/clear: the live port value is read, one bit changed and
    // the whole byte written back, so input pins pick up their level
    wire [2:0] bop_bit = wd8[2:0];
    wire       bop_set = wd8[`PPM_BOP_SET];
    wire       bop_a   = we_bop & ~wd8[`PPM_BOP_PORTB];
    wire       bop_b   = we_bop & wd8[`PPM_BOP_PORTB];
    wire [7:0] bmask_a = 8'h01 << bop_bit;
    wire [5:0] bmask_b = 6'h01 << bop_bit;
    wire [7:0] rmw_a   = bop_set ? (i_pa_in | bmask_a)
                                 : (i_pa_in & ~bmask_a);
    wire [5:0] rmw_b   = bop_set ? (i_pb_in | bmask_b)
                                 : (i_pb_in & ~bmask_b);

    wire [7:0] next_pa_data = we_pa_data ? wd8 :
                              bop_a      ? rmw_a : port_a_data;
    wire [5:0] next_pb_data = we_pb_data ? wd8[5:0] :
                              bop_b      ? rmw_b : port_b_data;

    ////////////////////////////////////////////////////////////////////
    // wake: enabled port A falling edges while asleep set sticky flags;
    // the edge is caught against the previous sample, and a write of one
    // clears a flag unless a new edge lands in the same cycle
    wire [7:0] pa_fall    = pa_prev & ~i_pa_in;
    wire [7:0] wake_set   = pa_fall & port_a_wake_enable
                            & {8{i_sleep}};
    wire [7:0] wake_clr   = we_wstat ? wd8 : `PPM_RST_ZERO8;
    wire [7:0] next_flags = (wake_flags & ~wake_clr) | wake_set;

    ////////////////////////////////////////////////////////////////////
    // function placement; remap only picks the pin, the select bits
    // themselves are untouched by it
    wire remap  = misc_control_zero[`PPM_MISC_REMAP];
    wire pfd_on = misc_control_zero[`PPM_MISC_PFD];
    wire pfd_a  = pfd_on & ~remap;
    wire pfd_b  = pfd_on & remap;

    localparam logic [7:0] M_PFD  = 8'h01 << `PPM_PA_PFD;
    localparam logic [7:0] M_PWM0 = 8'h01 << `PPM_PA_PWM0;
    localparam logic [7:0] M_PWM1 = 8'h01 << `PPM_PA_PWM1;
    localparam logic [5:0] M_BPFD = 6'h01 << `PPM_PB_PFD;

    // enable and value of the peripheral that owns each pin
    wire [7:0] pa_fen = ({8{pfd_a}} & M_PFD)
        | ({8{misc_control_zero[`PPM_MISC_PWM0]}} & M_PWM0)
        | ({8{misc_control_zero[`PPM_MISC_PWM1]}} & M_PWM1);
    wire [7:0] pa_fval = ({8{i_freq_div_output}} & M_PFD)
        | ({8{i_pwm[0]}} & M_PWM0) | ({8{i_pwm[1]}} & M_PWM1);
    wire [5:0] pb_fen  = {6{pfd_b}} & M_BPFD;
    wire [5:0] pb_fval = {6{i_freq_div_output}} & M_BPFD;

    // analog select per port A pin; pins past ADC_PINS never go analog
    wire [7:0] pa_analog;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_adc
            if (gi < ADC_PINS) begin : g_on
                assign pa_analog[gi] = adc_pin_config_bits[gi];
            end else begin : g_off
                assign pa_analog[gi] = 1'b0;
            end
        end
    endgenerate

    wire [5:0] pb_com = {2'b00, lcd_common_control};

    // the latch drives unless a selected peripheral owns the pin;
    // the driver is on only with direction output
    wire [7:0] pa_drv = (pa_fen & pa_fval) | (~pa_fen & port_a_data);
    wire [5:0] pb_drv = (pb_fen & pb_fval) | (~pb_fen & port_b_data);
    wire [7:0] pa_oen = port_a_direction | pa_analog;
    wire [5:0] pb_oen = port_b_direction | pb_com;
    // pull-high only on inputs, never on analog or lcd pins
    wire [7:0] pa_pu  = port_a_pullhigh_enable & port_a_direction
                        & ~pa_analog & PA_PULL_MASK;
    wire [5:0] pb_pu  = port_b_pullhigh_enable & port_b_direction
                        & ~pb_com;

    ////////////////////////////////////////////////////////////////////
    // input routing: pins keep their port read path, these only tap them
    wire int_lvl  = remap ? i_pb_in[`PPM_PB_INT] & port_b_direction[`PPM_PB_INT]
                          : i_pa_in[`PPM_PA_INT] & port_a_direction[`PPM_PA_INT];
    wire tc0_lvl  = remap ? i_pb_in[`PPM_PB_TC0] & port_b_direction[`PPM_PB_TC0]
                          : i_pa_in[`PPM_PA_TC0] & port_a_direction[`PPM_PA_TC0];
    wire tc1_lvl  = i_pa_in[`PPM_PA_TC1] & port_a_direction[`PPM_PA_TC1];
    wire t0_ext   = (timer0_mode == PPM_TM_EVENT)
                  | (timer0_mode == PPM_TM_CAPTURE);
    wire t1_ext   = (timer1_mode == PPM_TM_EVENT)
                  | (timer1_mode == PPM_TM_CAPTURE);

    ////////////////////////////////////////////////////////////////////
    // read mux: port data always returns the live pin level
    wire [31:0] rd_mux =
        (rd_addr == `PPM_A_PA_DATA)   ? {24'h0, i_pa_in} :
        (rd_addr == `PPM_A_PA_DIR)    ? {24'h0, port_a_direction} :
        (rd_addr == `PPM_A_PA_PULL)   ? {24'h0, port_a_pullhigh_enable} :
        (rd_addr == `PPM_A_PA_WAKE)   ? {24'h0, port_a_wake_enable} :
        (rd_addr == `PPM_A_PB_DATA)   ? {26'h0, i_pb_in} :
        (rd_addr == `PPM_A_PB_DIR)    ? {26'h0, port_b_direction} :
        (rd_addr == `PPM_A_PB_PULL)   ? {26'h0, port_b_pullhigh_enable} :
        (rd_addr == `PPM_A_MISC)      ? {28'h0, misc_control_zero} :
        (rd_addr == `PPM_A_LCD_COM)   ? {28'h0, lcd_common_control} :
        (rd_addr == `PPM_A_ADC_CTRL)  ? {24'h0, adc_pin_config_bits} :
        (rd_addr == `PPM_A_TMR_MODE)  ? {28'h0, timer1_mode, timer0_mode} :
        (rd_addr == `PPM_A_WAKE_STAT) ? {24'h0, wake_flags} :
                                        `PPM_RST_ZERO32;

    ////////////////////////////////////////////////////////////////////
    // bus slave: writes take no wait, reads one wait state so read data
    // always comes from a flop and sees the write just before it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bus_state   <= PPM_BUS_IDLE;
            wr_pend     <= 1'b0;
            wr_addr     <= `PPM_RST_ZERO8;
            rd_addr     <= `PPM_RST_ZERO8;
            o_hrdata    <= `PPM_RST_ZERO32;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            wr_pend <= addr_take & i_hwrite;
            if (addr_take) begin
                wr_addr <= i_haddr[7:0];
                rd_addr <= i_haddr[7:0];
            end
            case (bus_state)
                PPM_BUS_IDLE: begin
                    o_hreadyout <= ~rd_take;
                    if (rd_take) begin
                        bus_state <= PPM_BUS_RDWAIT;
                    end
                end
                PPM_BUS_RDWAIT: begin
                    o_hrdata    <= rd_mux;
                    o_hreadyout <= 1'b1;
                    bus_state   <= PPM_BUS_IDLE;
                end
                default: begin
                    o_hreadyout <= 1'b1;
                    bus_state   <= PPM_BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port and control registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            port_a_data            <= `PPM_RST_PA;
            port_a_direction       <= `PPM_RST_PA;
            port_b_data            <= `PPM_RST_PB;
            port_b_direction       <= `PPM_RST_PB;
            port_a_pullhigh_enable <= `PPM_RST_ZERO8;
            port_b_pullhigh_enable <= `PPM_RST_ZERO6;
            port_a_wake_enable     <= `PPM_RST_ZERO8;
            misc_control_zero      <= `PPM_RST_ZERO4;
            lcd_common_control     <= `PPM_RST_ZERO4;
            adc_pin_config_bits    <= `PPM_RST_ZERO8;
            timer0_mode            <= PPM_TM_OFF;
            timer1_mode            <= PPM_TM_OFF;
            wake_flags             <= `PPM_RST_ZERO8;
            pa_prev                <= i_pa_in;  // no false edge after reset
        end else begin
            port_a_data <= next_pa_data;
            port_b_data <= next_pb_data;
            wake_flags  <= next_flags;
            pa_prev     <= i_pa_in;
            if (we_pa_dir)  port_a_direction       <= wd8;
            if (we_pb_dir)  port_b_direction       <= wd8[5:0];
            if (we_pa_pull) port_a_pullhigh_enable <= wd8;
            if (we_pb_pull) port_b_pullhigh_enable <= wd8[5:0];
            if (we_pa_wake) port_a_wake_enable     <= wd8;
            if (we_misc)    misc_control_zero      <= wd8[3:0];
            if (we_lcd)     lcd_common_control     <= wd8[3:0];
            if (we_adc)     adc_pin_config_bits    <= wd8;
            if (we_tmr) begin
                timer0_mode <= ppm_tmode_t'(wd8[1:0]);
                timer1_mode <= ppm_tmode_t'(wd8[3:2]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered pin and function outputs, one cycle behind the state; o_wake is loaded from next_flags, in step with the flags
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pa_out           <= `PPM_RST_PA;
            o_pa_oe_n          <= `PPM_RST_PA;
            o_pa_pullup        <= `PPM_RST_ZERO8;
            o_pa_analog        <= `PPM_RST_ZERO8;
            o_pb_out           <= `PPM_RST_PB;
            o_pb_oe_n          <= `PPM_RST_PB;
            o_pb_pullup        <= `PPM_RST_ZERO6;
            o_pb_com_bias      <= `PPM_RST_ZERO4;
            o_ext_irq_pin      <= 1'b0;
            o_timer0_ext_input <= 1'b0;
            o_timer1_ext_input <= 1'b0;
            o_wake             <= 1'b0;
        end else begin
            o_pa_out           <= pa_drv;
            o_pa_oe_n          <= pa_oen;
            o_pa_pullup        <= pa_pu;
            o_pa_analog        <= pa_analog;
            o_pb_out           <= pb_drv;
            o_pb_oe_n          <= pb_oen;
            o_pb_pullup        <= pb_pu;
            o_pb_com_bias      <= lcd_common_control;
            o_ext_irq_pin      <= int_lvl;
            o_timer0_ext_input <= t0_ext & tc0_lvl;
            o_timer1_ext_input <= t1_ext & tc1_lvl;
            o_wake             <= |next_flags;
        end
    end

endmodule : ppm_port_mux
`default_nettype wire

/* shared/ppm_defs.svh */
// ppm_defs.svh: register offsets, reset values, bit positions and pin
// positions of the port pin function mux.
// assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

`define PPM_A_PA_DATA   8'h00
`define PPM_A_PA_DIR    8'h04
`define PPM_A_PA_PULL   8'h08
`define PPM_A_PA_WAKE   8'h0C
`define PPM_A_PB_DATA   8'h10
`define PPM_A_PB_DIR    8'h14
`define PPM_A_PB_PULL   8'h18
`define PPM_A_MISC      8'h1C
`define PPM_A_LCD_COM   8'h20
`define PPM_A_ADC_CTRL  8'h24
`define PPM_A_TMR_MODE  8'h28
`define PPM_A_BIT_OP    8'h2C
`define PPM_A_WAKE_STAT 8'h30

`define PPM_RST_PA      8'hFF
`define PPM_RST_PB      6'h3F
`define PPM_RST_ZERO8   8'h00
`define PPM_RST_ZERO6   6'h00
`define PPM_RST_ZERO4   4'h0
`define PPM_RST_ZERO32  32'h0000_0000

`define PPM_MISC_PFD    0
`define PPM_MISC_PWM0   1
`define PPM_MISC_PWM1   2
`define PPM_MISC_REMAP  3

`define PPM_BOP_PORTB   3
`define PPM_BOP_SET     4

`define PPM_PA_PFD      1
`define PPM_PA_TC0      2
`define PPM_PA_INT      3
`define PPM_PA_TC1      4
`define PPM_PA_PWM0     5
`define PPM_PA_PWM1     6
`define PPM_PB_PFD      3
`define PPM_PB_TC0      4
`define PPM_PB_INT      5

`define PPM_HTRANS_ACT  1

`endif

/* shared/ppm_pkg.sv */
// ppm_pkg: types of the port pin function mux.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ppm_pkg;
    // timer mode field as software writes it
    typedef enum logic [1:0] {
        PPM_TM_OFF     = 2'b00,
        PPM_TM_EVENT   = 2'b01,
        PPM_TM_TIMER   = 2'b10,
        PPM_TM_CAPTURE = 2'b11
    } ppm_tmode_t;

    // bus slave phase, gray along idle -> read wait
    typedef enum logic [1:0] {
        PPM_BUS_IDLE   = 2'b00,
        PPM_BUS_RDWAIT = 2'b01
    } ppm_bus_t;
endpackage : ppm_pkg
`default_nettype wire
